// ---- verification/tb_wakeup_timer_watchdog.sv ----
// self-checking bench for the wake-up timer with watchdog
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s expected %0d seen %0d", nm, e, g); end end
module tb_wakeup_timer_watchdog;
  localparam int P = 10;
  localparam int N = 20;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic sel = 1'b0, valid = 1'b1, stuck = 1'b0, twice = 1'b0;
  logic [7:0] delay = 8'h1E;
  logic done, meas_en, wake, rst_low;
  int n_mismatch = 0;
  int cmp_count = 0;
  // ==========
  // clock, design, controller
  always #20 clock_in = ~clock_in;
  wakeup_timer_watchdog #(.TICK_CYCLES(P), .INTERVAL_W(20)) DUT (
    .clock_in(clock_in), .rst_in(rst_in), .done_in(done), .select_high_in(sel),
    .measure_done_in(1'b1), .measure_valid_in(valid), .measure_ticks_in(20'h00014),
    .measure_enable_out(meas_en), .wake_out(wake), .system_reset_out_low(rst_low));
  uc_model ctrl (.clock_in(clock_in), .wake_in(wake), .stuck_in(stuck),
    .twice_in(twice), .delay_in(delay), .done_out(done));
  // ==========
  // helpers
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_lvl(input bit w, input logic lvl, input int bound, output int n);
    n = 0;
    while ((w ? wake : rst_low) !== lvl) begin
      @(posedge clock_in);
      #1;
      n++;
      if (n > bound) begin
        n_mismatch++;
        $display("[ERR] wait expected %0d seen %0d", lvl, n);
        final_report();
      end
    end
  endtask
  // width of the current pulse and rise-to-rise period
  task automatic cycle(output int w, output int p);
    int a;
    wait_lvl(1, 1'b0, N * P, w);
    wait_lvl(1, 1'b1, 2 * N * P, a);
    p = w + a;
  endtask
  // ==========
  // scenarios
  task automatic s_startup();
    int n;
    `CHK("measure_en", 1'b1, meas_en);
    wait_lvl(0, 1'b1, 50 * P, n);
    `CHK("startup_len", 1'b1, n >= 41 * P && n <= 45 * P);
    `CHK("measure_off", 1'b0, meas_en);
    wait_lvl(1, 1'b1, 3 * N * P, n);
    `CHK("first_wake", 1'b1, n >= N * P - P && n <= N * P + P);
  endtask
  task automatic s_periodic();
    int w, p;
    cycle(w, p);
    `CHK("wake_width", 1'b1, w >= 2 * P - 1 && w <= 2 * P + 1);
    `CHK("period", N * P, p);
    `CHK("reset_idle", 1'b1, rst_low);
  endtask
  task automatic s_early();
    int w, p;
    @(posedge clock_in);
    delay <= 8'h02;
    twice <= 1'b1;
    cycle(w, p);
    cycle(w, p);
    `CHK("wake_cut", 1'b1, w <= 8);
    `CHK("period_dbl", N * P, p);
    `CHK("no_reset", 1'b1, rst_low);
  endtask
  task automatic s_missed();
    int n, p;
    @(posedge clock_in);
    stuck <= 1'b1;
    cycle(n, p);
    wait_lvl(0, 1'b0, 2 * N * P, n);
    `CHK("missed_at", 1'b1, n >= N * P - 2 && n <= N * P + 2);
    `CHK("no_wake", 1'b0, wake);
    @(posedge clock_in);
    stuck <= 1'b0;
    wait_lvl(0, 1'b1, 40 * P, n);
    `CHK("reset_len", 1'b1, n >= 31 * P && n <= 33 * P);
    wait_lvl(1, 1'b1, 2 * N * P, n);
    `CHK("after_reset", 1'b1, n >= N * P - P && n <= N * P + P);
  endtask
  task automatic s_manual();
    int n;
    @(posedge clock_in);
    sel <= 1'b1;
    repeat (5) @(posedge clock_in);
    sel <= 1'b0;
    repeat (3 * P) @(posedge clock_in);
    #1;
    `CHK("glitch", 1'b1, rst_low);
    @(posedge clock_in);
    sel <= 1'b1;
    repeat (5 * P) @(posedge clock_in);
    #1;
    `CHK("manual_rst", 1'b0, rst_low);
    `CHK("manual_wake", 1'b0, wake);
    @(posedge clock_in);
    sel <= 1'b0;
    wait_lvl(0, 1'b1, 40 * P, n);
    `CHK("manual_len", 1'b1, n >= 33 * P && n <= 36 * P);
  endtask
  task automatic s_restart();
    int n;
    @(posedge clock_in);
    rst_in <= 1'b1;
    valid <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    sel <= 1'b1;
    repeat (20 * P) @(posedge clock_in);
    sel <= 1'b0;
    wait_lvl(0, 1'b1, 50 * P, n);
    `CHK("restart_len", 1'b1, n >= 42 * P && n <= 47 * P);
    wait_lvl(1, 1'b1, 2 * N * P, n);
    `CHK("min_interval", 1'b1, n >= 9 * P && n <= 11 * P);
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
    s_startup();
    s_periodic();
    s_early();
    s_missed();
    s_manual();
    s_restart();
    final_report();
  end
endmodule // tb_wakeup_timer_watchdog

// ---- verification/uc_model.sv ----
// controller model answering wake pulses
`timescale 1ns/1ps
module uc_model (
  // clock and wake
  input wire logic clock_in,
  input wire logic wake_in,
  // behaviour
  input wire logic stuck_in,
  input wire logic twice_in,
  input wire logic [7:0] delay_in,
  // acknowledge
  output logic done_out
);
  initial begin
    done_out = 1'b0;
    forever begin
      @(posedge clock_in);
      done_out <= stuck_in;
      if (wake_in && !stuck_in) begin
        repeat (delay_in) @(posedge clock_in);
        repeat (twice_in ? 2 : 1) begin
          done_out <= 1'b1;
          repeat (3) @(posedge clock_in);
          done_out <= 1'b0;
          repeat (3) @(posedge clock_in);
        end
        wait (!wake_in);
      end
    end
  end
endmodule // uc_model

// ---- verification/wakeup_timer_asserts.sv ----
// concurrent checks on the wake-up timer ports
`timescale 1ns/1ps
module wakeup_timer_asserts #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // inputs watched
  input wire logic done_in,
  input wire logic select_high_in,
  // outputs watched
  input wire logic measure_enable_out,
  input wire logic wake_out,
  input wire logic system_reset_out_low
);
  localparam int WAKE_MAX = 2 * TICK_CYCLES + 2;
  localparam int SEL_MIN = 2 * TICK_CYCLES + 3;
  localparam int RST_MIN = 31 * TICK_CYCLES;
  int sel_cnt;
  int low_cnt;
  logic ran;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ==========
  // helper counters
  always_ff @(posedge clock_in) sel_cnt <= (rst_in || !select_high_in) ? 0 : sel_cnt + 1;
  always_ff @(posedge clock_in) low_cnt <= (rst_in || system_reset_out_low) ? 0 : low_cnt + 1;
  always_ff @(posedge clock_in) ran <= !rst_in && (ran || system_reset_out_low);
  // ==========
  // properties
  a_measure_holds_reset: assert property (measure_enable_out |-> !system_reset_out_low)
    else $error("reset released while measuring");
  a_measure_only_once: assert property (ran |-> !measure_enable_out)
    else $error("measurement repeated");
  a_wake_in_run: assert property ($rose(wake_out) |-> $past(system_reset_out_low))
    else $error("wake raised in reset");
  a_reset_wake_low: assert property (!system_reset_out_low |-> !wake_out)
    else $error("wake high in reset");
  a_ack_ends_wake: assert property (wake_out && $rose(done_in) |-> ##[1:2] !wake_out)
    else $error("wake not cut by ack");
  a_wake_width: assert property ($rose(wake_out) |-> ##[1:WAKE_MAX] !wake_out)
    else $error("wake pulse too long");
  a_manual_reset: assert property (sel_cnt >= SEL_MIN |-> !system_reset_out_low)
    else $error("manual reset missed");
  a_reset_width: assert property ($rose(system_reset_out_low) |-> low_cnt >= RST_MIN)
    else $error("reset pulse too short");
endmodule // wakeup_timer_asserts

bind wakeup_timer_watchdog wakeup_timer_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .done_in(done_in),
  .select_high_in(select_high_in),
  .measure_enable_out(measure_enable_out),
  .wake_out(wake_out),
  .system_reset_out_low(system_reset_out_low)
);

// ---- verilog/tick_divider.sv ----
// divider producing the slow oscillator tick enable
`timescale 1ns/1ps
`include "wakeup_timer_defs.svh"
module tick_divider #(
  parameter int CYCLES = 250000
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // tick enable
  output logic tick_out
);
  logic [`TICK_W-1:0] count;

  // ==========================================
  // count clock cycles per tick
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else if (count == `TICK_W'(CYCLES - 1)) begin
      count <= '0;
      tick_out <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule // tick_divider

// ---- verilog/wakeup_timer_defs.svh ----
// timing constants and rule summary for the wake-up timer with watchdog
// Operation
// - wake interval selectable 100 ms to 7200 s, fixed by startup measurement.
// - missing acknowledge by that deadline drives reset low as new interval begins.
// - wake pulse each interval start, except first and after missed acknowledge.
// - wake output rests low, high only during a wake pulse.
// - only a low-to-high edge on done counts as acknowledge.
// - first acknowledge per interval acts; later ones ignored until next interval.
// - acknowledge clears only the watchdog counter; interval timer keeps running.
// - acknowledge while wake is high ends the wake pulse at once.
// - reset output low during power-on reset and startup measurement.
// - select pin high two consecutive oscillator ticks asserts reset low.
// - measure interval resistor once after power-on; never repeat.
// - missed acknowledge or manual reset asserts reset and restarts counters.
// - interval spans adjacent wake rises; resistor valid 500 ohm to 170 kohm.
// - reset fall to next reset fall or wake rise equals interval plus reset width; code: next watchdog reset falls width plus two intervals later.
// - manual reset during startup aborts measurement, restarted after release.
// - manual reset accepted only if high 20 ms within 30 ms window.
// - manual reset clears counters; resume after pin low plus reset width; code adds the 20 ms debounce before the reset width.
// - debounce manual reset; reset low for its length plus 20 ms plus width.
// - valid manual reset drives wake low and reset low.
// - after measurement, select pin routed to manual-reset detector.
// - select pin tied high is manual reset; no interval established.
// - startup measurement takes about 100 ms.
`ifndef WAKEUP_TIMER_DEFS_SVH
`define WAKEUP_TIMER_DEFS_SVH

`define CLOCK_PERIOD_NS 40
`define TICK_PERIOD_MS 10
`define TICK_CYCLES ((`TICK_PERIOD_MS * 1000000) / `CLOCK_PERIOD_NS)
`define INTERVAL_MIN_MS 100
`define INTERVAL_MAX_S 7200
`define INTERVAL_MIN_TICKS (`INTERVAL_MIN_MS / `TICK_PERIOD_MS)
`define INTERVAL_MAX_TICKS ((`INTERVAL_MAX_S * 1000) / `TICK_PERIOD_MS)
`define RESET_PULSE_WIDTH_MS 320
`define RESET_PULSE_TICKS (`RESET_PULSE_WIDTH_MS / `TICK_PERIOD_MS)
`define WAKE_PULSE_MS 20
`define WAKE_PULSE_TICKS (`WAKE_PULSE_MS / `TICK_PERIOD_MS)
`define ACK_WINDOW_DELAY_MS 20
`define ACK_WINDOW_TICKS (`ACK_WINDOW_DELAY_MS / `TICK_PERIOD_MS)
`define MANUAL_RESET_MIN_MS 20
`define MANUAL_RESET_MIN_TICKS (`MANUAL_RESET_MIN_MS / `TICK_PERIOD_MS)
`define DEBOUNCE_TIME_MS 20
`define DEBOUNCE_TICKS (`DEBOUNCE_TIME_MS / `TICK_PERIOD_MS)
`define MEASURE_MS 100
`define MEASURE_TICKS (`MEASURE_MS / `TICK_PERIOD_MS)
`define TICK_W 20
`define INTERVAL_W 20

`endif

// ---- verilog/wakeup_timer_pkg.sv ----
// types shared by the wake-up timer with watchdog
package wakeup_timer_pkg;
  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_MEASURE = 3'b001,
    ST_RESET = 3'b011,
    ST_RUN = 3'b010,
    ST_MANUAL = 3'b110
  } timer_state_t;
endpackage

// ---- verilog/wakeup_timer_watchdog.sv ----
// wake-up timer with watchdog: wake pulses, acknowledge supervision, manual reset
`timescale 1ns/1ps
`include "wakeup_timer_defs.svh"
module wakeup_timer_watchdog
  import wakeup_timer_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int INTERVAL_W = `INTERVAL_W
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // acknowledge from the controller
  input wire logic done_in,
  // interval-select pin, digital level
  input wire logic select_high_in,
  // measurement front end
  input wire logic measure_done_in,
  input wire logic measure_valid_in,
  input wire logic [INTERVAL_W-1:0] measure_ticks_in,
  output logic measure_enable_out,
  // outputs to the controller
  output logic wake_out,
  output logic system_reset_out_low
);
  localparam logic [INTERVAL_W-1:0] MIN_IP = INTERVAL_W'(`INTERVAL_MIN_TICKS);
  localparam logic [INTERVAL_W-1:0] MAX_IP = INTERVAL_W'(`INTERVAL_MAX_TICKS);
  localparam logic [INTERVAL_W-1:0] ACK_WIN = INTERVAL_W'(`ACK_WINDOW_TICKS);
  localparam logic [INTERVAL_W-1:0] WAKE_W = INTERVAL_W'(`WAKE_PULSE_TICKS);
  localparam logic [INTERVAL_W-1:0] RST_W = INTERVAL_W'(`RESET_PULSE_TICKS);
  localparam logic [INTERVAL_W-1:0] MEAS_W = INTERVAL_W'(`MEASURE_TICKS);
  localparam logic [INTERVAL_W-1:0] DB_W = INTERVAL_W'(`DEBOUNCE_TICKS);
  localparam logic [1:0] MR_MIN = 2'(`MANUAL_RESET_MIN_TICKS);

  timer_state_t state;
  logic tick;
  logic done_prev;
  logic ack_edge;
  logic acked;
  logic first_interval;
  logic measured;
  logic [INTERVAL_W-1:0] interval_period;
  logic [INTERVAL_W-1:0] phase;
  logic [INTERVAL_W-1:0] hold;
  logic [INTERVAL_W-1:0] wake_left;
  logic [1:0] select_run;
  logic select_sample;
  logic manual_hit;
  logic interval_end;

  // ==========================================
  // slow oscillator
  tick_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // ==========================================
  // manual reset detection on the select pin
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      select_sample <= 1'b0;
      select_run <= 2'h0;
    end else if (tick) begin
      select_sample <= select_high_in;
      if (!select_high_in) begin
        select_run <= 2'h0;
      end else if (select_run != 2'h3) begin
        select_run <= select_run + 2'h1;
      end
    end
  end
  // two consecutive high ticks, 20 ms within the 30 ms window
  assign manual_hit = (select_run >= MR_MIN);

  // ==========================================
  // acknowledge edge detection
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      done_prev <= 1'b0;
    end else begin
      done_prev <= done_in;
    end
  end
  assign ack_edge = done_in && !done_prev;

  // interval ends on the tick where phase reaches the programmed period minus one
  assign interval_end = tick && (state == ST_RUN) && (phase >= interval_period - 1'b1);

  // ==========================================
  // main sequencer
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= ST_POR;
      hold <= '0;
      measured <= 1'b0;
      interval_period <= MIN_IP;
    end else begin
      unique case (state)
        ST_POR: begin
          hold <= '0;
          state <= ST_MEASURE;
        end
        ST_MEASURE: begin
          if (manual_hit) begin
            state <= ST_MANUAL;
            hold <= '0;
          end else if (measure_done_in && tick && hold >= MEAS_W - 1'b1) begin
            measured <= 1'b1;
            if (measure_ticks_in < MIN_IP || !measure_valid_in) begin
              interval_period <= MIN_IP;
            end else if (measure_ticks_in > MAX_IP) begin
              interval_period <= MAX_IP;
            end else begin
              interval_period <= measure_ticks_in;
            end
            state <= ST_RESET;
            hold <= '0;
          end else if (tick && hold < MEAS_W - 1'b1) begin
            hold <= hold + 1'b1;
          end
        end
        ST_RESET: begin
          if (manual_hit) begin
            state <= ST_MANUAL;
            hold <= '0;
          end else if (tick) begin
            if (hold >= RST_W - 1'b1) begin
              state <= ST_RUN;
              hold <= '0;
            end else begin
              hold <= hold + 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (manual_hit) begin
            state <= ST_MANUAL;
            hold <= '0;
          end else if (interval_end && !acked && !first_interval) begin
            state <= ST_RESET;
            hold <= '0;
          end
        end
        ST_MANUAL: begin
          // held while the pin stays high, then debounce time
          if (tick) begin
            if (select_sample) begin
              hold <= '0;
            end else if (hold >= DB_W - 1'b1) begin
              hold <= '0;
              state <= measured ? ST_RESET : ST_MEASURE;
            end else begin
              hold <= hold + 1'b1;
            end
          end
        end
        default: begin
          state <= ST_POR;
          hold <= '0;
        end
      endcase
    end
  end

  // ==========================================
  // interval timer, untouched by acknowledges
  always_ff @(posedge clock_in) begin
    if (rst_in || state != ST_RUN) begin
      phase <= '0;
    end else if (interval_end) begin
      phase <= '0;
    end else if (tick) begin
      phase <= phase + 1'b1;
    end
  end

  // first interval after reset ends in a wake without needing an acknowledge, and gets no watchdog check
  always_ff @(posedge clock_in) begin
    if (rst_in || state != ST_RUN) begin
      first_interval <= 1'b1;
    end else if (interval_end) begin
      first_interval <= 1'b0;
    end
  end

  // ==========================================
  // watchdog acknowledge latch
  always_ff @(posedge clock_in) begin
    if (rst_in || state != ST_RUN) begin
      acked <= 1'b0;
    end else if (interval_end) begin
      acked <= 1'b0;
    end else if (ack_edge && !acked && (phase + ACK_WIN < interval_period)) begin
      acked <= 1'b1;
    end
  end

  // ==========================================
  // wake pulse generation
  always_ff @(posedge clock_in) begin
    // manual_hit drops wake together with the reset output, not a clock later
    if (rst_in || state != ST_RUN || manual_hit) begin
      wake_out <= 1'b0;
      wake_left <= '0;
    end else if (interval_end && (acked || first_interval)) begin
      wake_out <= 1'b1;
      wake_left <= WAKE_W;
    end else if (ack_edge && !acked) begin
      wake_out <= 1'b0;
      wake_left <= '0;
    end else if (tick && wake_left != '0) begin
      wake_left <= wake_left - 1'b1;
      if (wake_left == INTERVAL_W'(1)) begin
        wake_out <= 1'b0;
      end
    end
  end

  // ==========================================
  // reset output and measurement path enable
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      system_reset_out_low <= 1'b0;
      measure_enable_out <= 1'b0;
    end else begin
      system_reset_out_low <= (state == ST_RUN) && !manual_hit;
      measure_enable_out <= (state == ST_MEASURE) && !manual_hit;
    end
  end
endmodule // wakeup_timer_watchdog
